// [inc/wdgt_pkg.sv]
package wdgt_pkg;

  // ****************************************************************
  // register fields and constants
  // ****************************************************************
  localparam int unsigned PRE_W       = 13;
  localparam int unsigned CNT_W       = 8;
  localparam int unsigned MC_DIV      = 12;      // oscillator periods per cycle
  localparam int unsigned TAP_BASE    = 5;       // stage 6 is bit index 5
  localparam logic [3:0]  MC_LAST     = 4'hb;    // last phase of a machine cycle
  localparam logic [7:0]  FEED_FIRST  = 8'ha5;
  localparam logic [7:0]  FEED_SECOND = 8'h5a;
  localparam logic [7:0]  RELOAD_RST  = 8'hff;
  localparam logic [2:0]  TAP_RST     = 3'h7;    // slowest tap
  localparam int unsigned B_MODE      = 0;
  localparam int unsigned B_TOF       = 1;
  localparam int unsigned B_RUN       = 2;
  localparam int unsigned B_TAP_LO    = 5;
  localparam int unsigned B_TAP_HI    = 7;

  // ****************************************************************
  // carriers
  // ****************************************************************
  // one processor write toward the block's registers
  typedef struct packed {
    logic       ctrl_we;
    logic       reload_we;
    logic       feed1_we;
    logic       feed2_we;
    logic [7:0] wdata;
  } wdgt_wr_s;

  // fixed options used when the external access pin is high
  typedef struct packed {
    logic       mode_wd;
    logic [7:0] reload;
    logic [2:0] tap;
  } wdgt_mask_s;

  typedef enum logic [1:0] {
    WDGT_IDLE  = 2'b00,
    WDGT_ARMED = 2'b01
  } wdgt_feed_e;

endpackage : wdgt_pkg

// [src/wdgt_core.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - 13-bit prescaler steps each machine cycle; a top-eight tap clocks counter.
// - tap field selects divisor 12*64*2^n oscillator periods.
// - each tap clock decrements; watchdog underflow triggers system reset.
// - valid feed loads autoload value into counter and clears prescaler.
// - feed is A5 then 5A by the end of the next instruction; else immediate reset.
// - in timer mode the run bit starts and stops counting.
// - timeout flag set on underflow, cleared by reset or software zero.
// - mode bit one selects watchdog and blocks power-down.
// - watchdog mode leaves only by writing zero then feeding.
// - reset: timer mode, stopped, reload FF, flag clear, slowest tap, autoload.
// - feeds also work in timer mode.
// - reset coinciding with underflow wins; flag ends cleared.
// - watchdog underflow autoloads, sets flag, keeps settings, resets chip.
// - timer underflow autoloads, sets flag, raises timer interrupt instead.
// - interrupt flag clears on service entry or by direct software clear.
// - pin high takes mask options; pin low takes software registers.
// - masked timer mode still uses software reload, tap and run.
// - masked watchdog mode reads back mask mode bit only, ignores mode writes, run ignored.
// - underflow is a decrement clock at zero; reload zero is valid.
module wdgt_core
  import wdgt_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        clk_en,
  // processor write port
  input  wire wdgt_wr_s    wr,
  input  wire logic        instr_done,
  input  wire logic        tof_clr_n,
  input  wire logic        irq_ack,
  input  wire logic        irq_clr,
  // mask options
  input  wire logic        external_access_pin,
  input  wire wdgt_mask_s  mask_opt,
  // status and events
  output logic [7:0]       watchdog_control,
  output logic [7:0]       count_q,
  output logic             sys_reset_req,
  output logic             timer_irq,
  output logic             pd_block
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [3:0]       osc_ph_q;
  logic [PRE_W-1:0] pre_q;
  logic [CNT_W-1:0] cnt_q;
  logic [7:0]       reload_q;
  logic [2:0]       tap_q;
  logic             run_q;
  logic             tof_q;
  logic             mode_q;
  logic             mode_clr_pend_q;
  logic             irq_q;
  logic             rst_req_q;
  logic             mode_rd_q;
  wdgt_feed_e       feed_q;

  // ****************************************************************
  // effective parameters
  // ****************************************************************
  logic       use_mask;
  logic       eff_mode;
  logic [7:0] eff_reload;
  logic [2:0] eff_tap;
  logic       counting;
  logic       mc_tick;
  logic       tap_tick;
  logic       underflow;
  logic       feed_ok;
  logic       feed_bad;
  logic [PRE_W-1:0] tap_mask;

  // mask mode applies whenever the pin is high; mask reload and tap only under the watchdog-mode mask; timer mode keeps sw
  always_comb begin
    use_mask   = external_access_pin;
    eff_mode   = use_mask ? mask_opt.mode_wd : mode_q;
    eff_reload = (use_mask && mask_opt.mode_wd) ? mask_opt.reload
                                                : reload_q;
    eff_tap    = (use_mask && mask_opt.mode_wd) ? mask_opt.tap
                                                : tap_q;
    counting   = eff_mode ? (use_mask ? 1'b1 : run_q)
                          : run_q;
  end

  // ****************************************************************
  // prescaler and feed detection
  // ****************************************************************
  // machine cycle ends on the twelfth oscillator phase
  assign mc_tick = (osc_ph_q == MC_LAST);
  // a 1-to-0 edge of the chosen stage marks one tap period: the stage and
  // all below it read ones on the machine cycle that carries over
  assign tap_mask = ((PRE_W)'(1) << (TAP_BASE + 32'(eff_tap) + 1)) -
                    (PRE_W)'(1);
  assign tap_tick = mc_tick && counting &&
                    ((pre_q & tap_mask) == tap_mask);
  assign underflow = tap_tick && (cnt_q == '0);
  assign feed_ok   = (feed_q == WDGT_ARMED) && wr.feed2_we &&
                     (wr.wdata == FEED_SECOND);
  // anything but the second write on the next instruction aborts
  assign feed_bad  = (feed_q == WDGT_ARMED) && instr_done && !feed_ok;

  // oscillator phase counter, divide by twelve
  always_ff @(posedge mclk) begin
    if (srst) begin
      osc_ph_q <= '0;
    end else if (clk_en) begin
      osc_ph_q <= mc_tick ? 4'h0 : osc_ph_q + 4'h1;
    end
  end

  // prescaler counts machine cycles, cleared by feed or autoload
  always_ff @(posedge mclk) begin
    if (srst) begin
      pre_q <= '0;
    end else if (clk_en) begin
      if (feed_ok || underflow) begin
        pre_q <= '0;
      end else if (mc_tick && counting) begin
        pre_q <= pre_q + (PRE_W)'(1);
      end
    end
  end

  // feed sequencer
  always_ff @(posedge mclk) begin
    if (srst) begin
      feed_q <= WDGT_IDLE;
    end else if (clk_en) begin
      unique case (feed_q)
        WDGT_IDLE: begin
          if (wr.feed1_we && wr.wdata == FEED_FIRST) begin
            feed_q <= WDGT_ARMED;
          end
        end
        WDGT_ARMED: begin
          if (instr_done) begin
            feed_q <= WDGT_IDLE;
          end
        end
        default: feed_q <= WDGT_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // main counter
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_q <= RELOAD_RST;
    end else if (clk_en) begin
      if (feed_ok || underflow) begin
        cnt_q <= eff_reload;
      end else if (tap_tick) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // ****************************************************************
  // control register fields
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (srst) begin
      reload_q <= RELOAD_RST;
      tap_q    <= TAP_RST;
      run_q    <= 1'b0;
    end else if (clk_en) begin
      if (wr.reload_we) begin
        reload_q <= wr.wdata;
      end
      if (wr.ctrl_we) begin
        tap_q <= wr.wdata[B_TAP_HI:B_TAP_LO];
        run_q <= wr.wdata[B_RUN];
      end
    end
  end

  // mode: set by write, cleared only by write of zero followed by feed
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_q          <= 1'b0;
      mode_clr_pend_q <= 1'b0;
    end else if (clk_en) begin
      if (wr.ctrl_we && !(use_mask && mask_opt.mode_wd)) begin
        if (wr.wdata[B_MODE]) begin
          mode_q          <= 1'b1;
          mode_clr_pend_q <= 1'b0;
        end else if (mode_q) begin
          mode_clr_pend_q <= 1'b1;
        end
      end else if (feed_ok && mode_clr_pend_q) begin
        mode_q          <= 1'b0;
        mode_clr_pend_q <= 1'b0;
      end
    end
  end

  // timeout flag; hardware set beats software clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      tof_q <= 1'b0;
    end else if (clk_en) begin
      if (underflow) begin
        tof_q <= 1'b1;
      end else if (wr.ctrl_we && !wr.wdata[B_TOF] && !tof_clr_n) begin
        tof_q <= 1'b0;
      end else if (wr.ctrl_we && !wr.wdata[B_TOF]) begin
        tof_q <= 1'b0;
      end
    end
  end

  // timer interrupt flag, untouched by watchdog-mode underflow
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      if (underflow && !eff_mode) begin
        irq_q <= 1'b1;
      end else if (irq_ack || irq_clr) begin
        irq_q <= 1'b0;
      end
    end
  end

  // system reset request: watchdog underflow or broken feed pair
  always_ff @(posedge mclk) begin
    if (srst) begin
      rst_req_q <= 1'b0;
    end else if (clk_en) begin
      rst_req_q <= (underflow && eff_mode) || feed_bad;
    end
  end

  // effective mode copied into a flop so readback and power-down block
  // come from registers; they trail a pin or mode change by one cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_rd_q <= 1'b0;
    end else if (clk_en) begin
      mode_rd_q <= eff_mode;
    end
  end

  // ****************************************************************
  // outputs, all registered
  // ****************************************************************
  assign watchdog_control = {tap_q, 2'b00, run_q, tof_q, mode_rd_q};
  assign count_q          = cnt_q;
  assign sys_reset_req    = rst_req_q;
  assign timer_irq        = irq_q;
  assign pd_block         = mode_rd_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_feed_loads: assert property (@(posedge mclk) disable iff (srst)
    clk_en && feed_ok |=> cnt_q == $past(eff_reload) && pre_q == '0)
    else $error("feed did not reload counter");
  a_bad_feed_rst: assert property (@(posedge mclk) disable iff (srst)
    clk_en && feed_bad |=> sys_reset_req)
    else $error("broken feed pair gave no reset");
  a_wd_uf_rst: assert property (@(posedge mclk) disable iff (srst)
    clk_en && underflow && eff_mode |=> sys_reset_req && tof_q &&
    (!irq_q || $past(irq_q)))
    else $error("watchdog underflow gave no reset");
  a_tmr_uf_irq: assert property (@(posedge mclk) disable iff (srst)
    clk_en && underflow && !eff_mode |=>
    timer_irq && sys_reset_req == $past(feed_bad))
    else $error("timer underflow gave no interrupt");
  a_tof_set: assert property (@(posedge mclk) disable iff (srst)
    clk_en && underflow |=> tof_q)
    else $error("timeout flag not set");
  a_stop_hold: assert property (@(posedge mclk) disable iff (srst)
    !counting && !feed_ok |=> $stable(cnt_q))
    else $error("stopped counter changed");
  a_pd_block: assert property (@(posedge mclk) disable iff (srst)
    clk_en && eff_mode |=> pd_block)
    else $error("power-down not blocked");
  a_mode_sticky: assert property (@(posedge mclk) disable iff (srst)
    clk_en && mode_q && !feed_ok |=> mode_q)
    else $error("watchdog mode left without feed");
  a_uf_reload: assert property (@(posedge mclk) disable iff (srst)
    clk_en && underflow |=> cnt_q == $past(eff_reload))
    else $error("underflow did not autoload counter");
  a_irq_clear: assert property (@(posedge mclk) disable iff (srst)
    clk_en && (irq_ack || irq_clr) && !underflow |=> !timer_irq)
    else $error("interrupt flag not cleared");
  a_freeze_hold: assert property (@(posedge mclk) disable iff (srst)
    !clk_en |=> $stable(cnt_q) && $stable(pre_q) && $stable(tof_q))
    else $error("state moved while clock enable low");
  c_feed: cover property (@(posedge mclk) feed_ok);
  c_bad_feed: cover property (@(posedge mclk) feed_bad);
  c_mode_leave: cover property (@(posedge mclk) feed_ok && mode_clr_pend_q);
  c_wd_uf: cover property (@(posedge mclk) underflow && eff_mode);
  c_tmr_uf: cover property (@(posedge mclk) underflow && !eff_mode);

endmodule : wdgt_core
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wdgt_pkg::*;

  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic       mclk, srst, clk_en, instr_done, irq_ack, irq_clr;
  logic       external_access_pin, sys_reset_req, timer_irq, pd_block;
  wdgt_wr_s   wr;
  wdgt_mask_s mask_opt;
  logic [7:0] watchdog_control, count_q;
  int         n_mismatch, num_checks, cyc, n;

  wdgt_core dut_u (
    .mclk(mclk), .srst(srst), .clk_en(clk_en), .wr(wr),
    .instr_done(instr_done), .tof_clr_n(1'b1), .irq_ack(irq_ack),
    .irq_clr(irq_clr), .external_access_pin(external_access_pin),
    .mask_opt(mask_opt), .watchdog_control(watchdog_control),
    .count_q(count_q), .sys_reset_req(sys_reset_req),
    .timer_irq(timer_irq), .pd_block(pd_block)
  );

  // 20 MHz oscillator
  always #25 mclk = ~mclk;

  // hang guard, well above the longest sequence of waits
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // machine-cycle phase is not cleared by a feed, so allow a slack
  task automatic chk_near(input int got, input int exp);
    num_checks++;
    if (got < exp - 14 || got > exp + 14) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_near

  // k: 0 control, 1 reload
  task automatic wr_reg(input int k, input logic [7:0] d);
    @(posedge mclk);
    wr.ctrl_we   <= (k == 0);
    wr.reload_we <= (k == 1);
    wr.wdata     <= d;
    @(posedge mclk);
    wr <= '0;
  endtask : wr_reg

  // good == 0 leaves out the second write to provoke a reset
  task automatic feed(input bit good);
    @(posedge mclk);
    wr.feed1_we <= 1'b1;
    wr.wdata    <= FEED_FIRST;
    @(posedge mclk);
    wr.feed1_we <= 1'b0;
    wr.feed2_we <= good;
    wr.wdata    <= FEED_SECOND;
    instr_done  <= 1'b1;
    @(posedge mclk);
    wr         <= '0;
    instr_done <= 1'b0;
  endtask : feed

  // k: 0 service entry, 1 software clear
  task automatic pulse(input int k);
    @(posedge mclk);
    irq_ack <= (k == 0);
    irq_clr <= (k == 1);
    @(posedge mclk);
    irq_ack <= 1'b0;
    irq_clr <= 1'b0;
  endtask : pulse

  // sel: 0 interrupt, 1 reset pulse, 2 counter change
  task automatic wait_ev(input int sel, input int lim, output int k);
    logic [7:0] last;
    last = count_q;
    k    = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (k < lim && !((sel == 0 && timer_irq === 1'b1) ||
               (sel == 1 && sys_reset_req === 1'b1) ||
               (sel == 2 && count_q !== last)));
  endtask : wait_ev

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    mclk = 0; srst = 1; clk_en = 1; instr_done = 0; irq_ack = 0;
    irq_clr = 0; external_access_pin = 0; wr = '0; mask_opt = '0;
    n_mismatch = 0; num_checks = 0; cyc = 0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    #1;
    chk(watchdog_control, 8'he0);
    chk(count_q, RELOAD_RST);
    chk({5'h0, timer_irq, sys_reset_req, pd_block}, 8'h00);
    // decrement spacing for the three fastest taps, timer mode
    wr_reg(1, 8'h05);
    for (int t = 0; t < 3; t++) begin
      wr_reg(0, {3'(t), 5'h04});
      feed(1'b1);
      #1 chk(count_q, 8'h05);
      wait_ev(2, 8000, n);
      chk_near(n, 768 << t);
      chk(count_q, 8'h04);
    end
    // run bit cleared stops the count
    wr_reg(0, 8'h20);
    wait_ev(2, 2000, n);
    chk(count_q, 8'h04);
    // timer underflow from a zero reload
    wr_reg(1, 8'h00);
    wr_reg(0, 8'h04);
    feed(1'b1);
    wait_ev(0, 2000, n);
    chk_near(n, 768);
    chk(watchdog_control, 8'h06);
    chk(count_q, 8'h00);
    chk({7'h0, sys_reset_req}, 8'h00);
    pulse(0);
    #1 chk({7'h0, timer_irq}, 8'h00);
    wait_ev(0, 2000, n);
    pulse(1);
    #1 chk({7'h0, timer_irq}, 8'h00);
    wr_reg(0, 8'h00);
    #1 chk(watchdog_control, 8'h00);
    // watchdog mode: underflow pulses reset, settings kept
    wr_reg(0, 8'h05);
    @(posedge mclk);
    #1 chk({7'h0, pd_block}, 8'h01);
    feed(1'b1);
    wait_ev(1, 2000, n);
    chk_near(n, 768);
    #1 chk(watchdog_control, 8'h07);
    chk({7'h0, timer_irq}, 8'h00);
    // broken feed pair resets at once
    feed(1'b0);
    #1 chk({7'h0, sys_reset_req}, 8'h01);
    @(posedge mclk);
    #1 chk({7'h0, sys_reset_req}, 8'h00);
    // leaving watchdog mode needs a feed after the zero write
    wr_reg(0, 8'h04);
    #1 chk(watchdog_control, 8'h05);
    feed(1'b1);
    @(posedge mclk);
    #1 chk(watchdog_control, 8'h04);
    // mask options with the access pin high fix watchdog mode
    external_access_pin <= 1'b1;
    mask_opt <= '{mode_wd: 1'b1, reload: 8'h00, tap: 3'h0};
    wr_reg(0, 8'h00);
    #1 chk({7'h0, watchdog_control[B_MODE]}, 8'h01);
    chk({7'h0, pd_block}, 8'h01);
    external_access_pin <= 1'b0;
    // reset in mid-run clears everything again
    srst <= 1'b1;
    @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    #1 chk(watchdog_control, 8'he0);
    chk(count_q, RELOAD_RST);
    wrap_up();
  end

endmodule : tb
`default_nettype wire
